//--- logic/sap_pkg.sv
package sap_pkg;

   // Register offsets, byte addresses on the bus
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CFG_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;

   // Write masks; reserved bits never store a one
   localparam logic [15:0] CTRL_WMASK = 16'hC303;
   localparam logic [15:0] CFG_WMASK = 16'hFF03;

   // Reset values
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] CFG_RST = 16'h0301;

   // Status write-one-to-clear position
   localparam int unsigned STAT_OVR_BIT = 3;

   // Port operating control layout
   typedef struct packed {
      logic sck_en;
      logic fs_en;
      logic [3:0] rsvd_hi;
      logic tx_en;
      logic rx_en;
      logic [5:0] rsvd_lo;
      logic tx_rst;
      logic rx_rst;
   } sap_ctrl_type;

   // Configuration layout: bit clock divider, idle drive, master select
   typedef struct packed {
      logic [7:0] div;
      logic [5:0] rsvd;
      logic hiz;
      logic master;
   } sap_cfg_type;

   // Status layout
   typedef struct packed {
      logic [11:0] rsvd;
      logic rx_ovr;
      logic tx_space;
      logic rx_act;
      logic tx_act;
   } sap_stat_type;

   // Synchronised pin group, one bit each
   typedef struct packed {
      logic sck;
      logic sync;
      logic rxd;
   } sap_pins_type;

endpackage : sap_pkg

//--- logic/sap_port_ctrl.sv
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps
// Function
// (RQ1) 16-bit readable writable operating control register
// (RQ2) Bit 15 gates serial clock, low when off
// (RQ3) Clock enable restarts baud generator and output
// (RQ4) Bit 14 gates frame sync, low when off
// (RQ5) Sync enable restarts frame counter
// (RQ6) Bit 9 permits transmit data output
// (RQ7) Bit 8 permits receive data capture
// (RQ8) Enable changes apply at next frame start
// (RQ9) Active transmit raises requests by watermark
// (RQ10) Shifting starts only when transmit data held
// (RQ11) Active receive captures from receive pin
// (RQ12) Received data raises requests by watermark
// (RQ13) Transmit path reset clears transmit enable
// (RQ14) Receive path reset clears receive enable
// (RQ15) Module stop clears four enable bits
// (RQ16) Reserved bits read zero, written zero
// (RQ17) Idle transmit pin drives high or floats
// (RQ18) Transmit reset forces pin high, clears path
// (RQ19) Watermarks come in, requests go out

// Two-entry buffer, head always in slot 0
module sap_buf2 #(
   parameter int W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic flush_i,
   input wire logic [W-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [W-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   logic [W-1:0] slot1_r;
   logic occ1_r;
   logic push;
   logic pop;
   logic occ0_nxt;
   logic occ1_nxt;

   // Handshake decode
   assign push = in_valid_i & in_ready_o; // Nothing taken while ready is low
   assign pop = out_valid_o & out_ready_i;
   assign occ0_nxt = ~flush_i & (push | (out_valid_o & ~pop) | occ1_r);
   assign occ1_nxt = ~flush_i & ((occ1_r & ~pop) | (push & out_valid_o & ~pop));

   // Slot movement
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_valid_o <= 1'b0;
         occ1_r <= 1'b0;
         in_ready_o <= 1'b0;
      end else begin
         out_valid_o <= occ0_nxt;
         occ1_r <= occ1_nxt;
         in_ready_o <= ~occ1_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (pop) begin
         out_data_o <= occ1_r ? slot1_r : in_data_i;
      end else if (push & ~out_valid_o) begin
         out_data_o <= in_data_i;
      end
      if (push & out_valid_o & ~(pop & ~occ1_r)) begin
         slot1_r <= in_data_i;
      end
   end
endmodule : sap_buf2

module sap_port_ctrl
   import sap_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter int FRAME_LOG2 = 5,
   parameter int LVL_W = 5
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // System
   input wire logic module_stop_i,
   // FIFO side
   input wire logic [DATA_W-1:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   output logic [DATA_W-1:0] rx_data_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   input wire logic [LVL_W-1:0] tx_fifo_level_i,
   input wire logic [LVL_W-1:0] transmit_fifo_watermark_i,
   input wire logic [LVL_W-1:0] rx_fifo_level_i,
   input wire logic [LVL_W-1:0] receive_fifo_watermark_i,
   output logic tx_req_o,
   output logic rx_req_o,
   // Serial pins
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe_o,
   input wire logic frame_sync_pin_i,
   output logic frame_sync_pin_o,
   output logic frame_sync_pin_oe_o,
   output logic transmit_data_pin_o,
   output logic transmit_data_pin_oe_o,
   input wire logic receive_data_pin_i
);
   localparam int CW = $clog2(DATA_W + 1);

   sap_ctrl_type ctrl_r;
   sap_ctrl_type ctrl_nxt;
   sap_cfg_type cfg_r;
   sap_stat_type stat;
   logic ack_r;
   logic rx_ovr_r;
   logic [7:0] brg_cnt_r;
   logic sck_r;
   logic [FRAME_LOG2-1:0] bit_cnt_r;
   logic [FRAME_LOG2-1:0] bit_inc;
   logic sync_r;
   sap_pins_type sy1_r;
   sap_pins_type sy2_r;
   sap_pins_type sy3_r;
   sap_pins_type lvl_r;
   sap_pins_type lvl_nxt;
   logic tx_act_r;
   logic rx_act_r;
   logic [DATA_W-1:0] tx_sh_r;
   logic [CW-1:0] tx_cnt_r;
   logic [DATA_W-1:0] rx_sh_r;
   logic [CW-1:0] rx_cnt_r;
   logic rx_word_r;
   logic txd_r;
   logic txd_oe_r;

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel, input logic [15:0] mask);
      logic [15:0] lanes;
      lanes = {{8{sel[1]}}, {8{sel[0]}}};
      merge16 = ((old & ~lanes) | (dat[15:0] & lanes)) & mask;
   endfunction : merge16

   // Bus decode
   logic req;
   logic wr_stb;
   logic hit_ctrl;
   logic hit_cfg;
   logic hit_stat;
   logic [31:0] rd_word;
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_stb = req & ack_r & wb_we_i;
   assign hit_ctrl = wb_adr_i == CTRL_OFS;
   assign hit_cfg = wb_adr_i == CFG_OFS;
   assign hit_stat = wb_adr_i == STAT_OFS;
   assign stat = '{rsvd: 12'h000, rx_ovr: rx_ovr_r, tx_space: tx_ready_o,
                   rx_act: rx_act_r, tx_act: tx_act_r};
   assign rd_word = hit_ctrl ? {16'h0000, ctrl_r & CTRL_WMASK} : // RQ16
                    hit_cfg ? {16'h0000, cfg_r & CFG_WMASK} :
                    hit_stat ? {16'h0000, stat} : 32'h0000_0000;

   // Control next value: write, then path resets, then module stop
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_stb & hit_ctrl) begin
         ctrl_nxt = merge16(ctrl_r, wb_dat_i, wb_sel_i, CTRL_WMASK); // RQ1
      end
      if (ctrl_nxt.tx_rst) begin
         ctrl_nxt.tx_en = 1'b0; // RQ13
      end
      if (ctrl_nxt.rx_rst) begin
         ctrl_nxt.rx_en = 1'b0; // RQ14
      end
      if (module_stop_i) begin
         ctrl_nxt.sck_en = 1'b0; // RQ15
         ctrl_nxt.fs_en = 1'b0;
         ctrl_nxt.tx_en = 1'b0;
         ctrl_nxt.rx_en = 1'b0;
      end
   end

   // Bus slave: one-cycle answer, write lands on the acked edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl_r <= CTRL_RST;
         cfg_r <= CFG_RST;
      end else begin
         ack_r <= req & ~ack_r;
         wb_dat_o <= (req & ~ack_r) ? rd_word : wb_dat_o;
         ctrl_r <= ctrl_nxt;
         if (wr_stb & hit_cfg) begin
            cfg_r <= merge16(cfg_r, wb_dat_i, wb_sel_i, CFG_WMASK);
         end
      end
   end
   assign wb_ack_o = ack_r;

   // Baud generator and frame counter decode
   logic sck_start;
   logic fs_start;
   logic brg_tick;
   logic m_rise;
   logic m_fall;
   logic m_frame;
   assign sck_start = ctrl_nxt.sck_en & ~ctrl_r.sck_en;
   assign fs_start = ctrl_nxt.fs_en & ~ctrl_r.fs_en;
   assign brg_tick = ctrl_r.sck_en & cfg_r.master & (brg_cnt_r == cfg_r.div);
   assign m_rise = brg_tick & ~sck_r;
   assign m_fall = brg_tick & sck_r;
   assign bit_inc = bit_cnt_r + 1'b1;
   assign m_frame = m_fall & ctrl_r.fs_en & (bit_inc == '0);

   // Master clock and sync generation
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         brg_cnt_r <= 8'h00;
         sck_r <= 1'b0;
         bit_cnt_r <= '1;
         sync_r <= 1'b0;
      end else begin
         if (sck_start | ~ctrl_nxt.sck_en | brg_tick) begin
            brg_cnt_r <= 8'h00; // RQ3
         end else begin
            brg_cnt_r <= brg_cnt_r + 8'h01;
         end
         if (~ctrl_nxt.sck_en | sck_start | ~cfg_r.master) begin
            sck_r <= 1'b0; // RQ2 RQ3
         end else if (brg_tick) begin
            sck_r <= ~sck_r;
         end
         if (fs_start) begin
            bit_cnt_r <= '1; // RQ5
         end else if (m_fall) begin
            bit_cnt_r <= bit_inc;
         end
         if (~ctrl_nxt.fs_en | ~cfg_r.master) begin
            sync_r <= 1'b0; // RQ4
         end else if (m_fall) begin
            sync_r <= bit_inc == '0;
         end
      end
   end
   assign serial_clock_pin_o = sck_r;
   assign serial_clock_pin_oe_o = cfg_r.master;
   assign frame_sync_pin_o = sync_r;
   assign frame_sync_pin_oe_o = cfg_r.master;

   // Pin synchronisers; a change counts once stages two and three agree
   sap_pins_type agree;
   assign agree = ~(sy2_r ^ sy3_r);
   assign lvl_nxt = (agree & sy3_r) | (~agree & lvl_r);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sy1_r <= '0;
         sy2_r <= '0;
         sy3_r <= '0;
         lvl_r <= '0;
      end else begin
         sy1_r <= '{sck: serial_clock_pin_i, sync: frame_sync_pin_i, rxd: receive_data_pin_i};
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         lvl_r <= lvl_nxt;
      end
   end

   // Common bit and frame events for both modes
   logic bit_rise;
   logic bit_fall;
   logic frame_start;
   assign bit_rise = cfg_r.master ? m_rise : (lvl_nxt.sck & ~lvl_r.sck);
   assign bit_fall = cfg_r.master ? m_fall : (~lvl_nxt.sck & lvl_r.sck);
   assign frame_start = cfg_r.master ? m_frame : (lvl_nxt.sync & ~lvl_r.sync);

   // Enables latched at the frame boundary
   logic tx_act_nxt;
   logic rx_act_nxt;
   assign tx_act_nxt = ctrl_nxt.tx_rst ? 1'b0 : frame_start ? ctrl_r.tx_en : tx_act_r; // RQ8
   assign rx_act_nxt = ctrl_nxt.rx_rst ? 1'b0 : frame_start ? ctrl_r.rx_en : rx_act_r; // RQ8

   // Transmit buffer
   logic [DATA_W-1:0] tbuf_data;
   logic tbuf_valid;
   logic tx_load;
   assign tx_load = frame_start & tx_act_nxt & tbuf_valid; // RQ6 RQ10
   sap_buf2 #(.W(DATA_W)) u_tbuf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .flush_i(ctrl_r.tx_rst),
      .in_data_i(tx_data_i),
      .in_valid_i(tx_valid_i),
      .in_ready_o(tx_ready_o),
      .out_data_o(tbuf_data),
      .out_valid_o(tbuf_valid),
      .out_ready_i(tx_load)
   );

   // Transmit shifter, MSB first, changes on falling bit edge
   logic tx_busy;
   logic [CW-1:0] tx_cnt_nxt;
   logic [DATA_W-1:0] tx_sh_nxt;
   assign tx_busy = tx_cnt_r != '0;
   assign tx_cnt_nxt = ctrl_nxt.tx_rst ? '0 : // RQ18
                       tx_load ? CW'(DATA_W) :
                       (bit_fall & tx_busy) ? tx_cnt_r - 1'b1 : tx_cnt_r;
   assign tx_sh_nxt = tx_load ? tbuf_data :
                      (bit_fall & tx_busy) ? {tx_sh_r[DATA_W-2:0], 1'b1} : tx_sh_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_cnt_r <= '0;
         tx_sh_r <= '0;
         txd_r <= 1'b1;
         txd_oe_r <= 1'b1; // Idle line driven high out of reset
         tx_act_r <= 1'b0;
         rx_act_r <= 1'b0;
      end else begin
         tx_cnt_r <= tx_cnt_nxt;
         tx_sh_r <= tx_sh_nxt;
         txd_r <= (tx_cnt_nxt != '0) ? tx_sh_nxt[DATA_W-1] : 1'b1; // RQ17 RQ18
         txd_oe_r <= ctrl_nxt.tx_rst | (tx_cnt_nxt != '0) | ~cfg_r.hiz; // RQ17
         tx_act_r <= tx_act_nxt;
         rx_act_r <= rx_act_nxt;
      end
   end
   assign transmit_data_pin_o = txd_r;
   assign transmit_data_pin_oe_o = txd_oe_r;

   // Receive shifter, samples on rising bit edge
   logic rbuf_ready;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_cnt_r <= '0;
         rx_sh_r <= '0;
         rx_word_r <= 1'b0;
      end else begin
         rx_word_r <= 1'b0;
         if (~rx_act_nxt) begin
            rx_cnt_r <= '0; // RQ7
         end else if (frame_start) begin
            rx_cnt_r <= CW'(DATA_W); // RQ11
         end else if (bit_rise & (rx_cnt_r != '0)) begin
            rx_sh_r <= {rx_sh_r[DATA_W-2:0], lvl_r.rxd};
            rx_cnt_r <= rx_cnt_r - 1'b1;
            rx_word_r <= rx_cnt_r == CW'(1);
         end
      end
   end

   // Receive buffer toward the receive FIFO
   sap_buf2 #(.W(DATA_W)) u_rbuf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .flush_i(ctrl_r.rx_rst),
      .in_data_i(rx_sh_r),
      .in_valid_i(rx_word_r),
      .in_ready_o(rbuf_ready),
      .out_data_o(rx_data_o),
      .out_valid_o(rx_valid_o),
      .out_ready_i(rx_ready_i)
   );

   // Overrun flag; a new overrun wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i | ctrl_r.rx_rst) begin
         rx_ovr_r <= 1'b0;
      end else if (rx_word_r & ~rbuf_ready) begin
         rx_ovr_r <= 1'b1;
      end else if (wr_stb & hit_stat & wb_sel_i[0] & wb_dat_i[STAT_OVR_BIT]) begin
         rx_ovr_r <= 1'b0;
      end
   end

   // Transfer requests by watermark
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_req_o <= 1'b0;
         rx_req_o <= 1'b0;
      end else begin
         tx_req_o <= tx_act_r & (tx_fifo_level_i <= transmit_fifo_watermark_i); // RQ9 RQ19
         rx_req_o <= rx_act_r & (rx_fifo_level_i != '0) &
                     (rx_fifo_level_i >= receive_fifo_watermark_i); // RQ12 RQ19
      end
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) // RQ1
      else $error("ack held longer than one cycle");
   a_sck_low_off: assert property (!ctrl_r.sck_en |-> !serial_clock_pin_o) // RQ2
      else $error("serial clock active while disabled");
   a_brg_restart: assert property ($rose(ctrl_r.sck_en) |-> brg_cnt_r == 8'h00 && !sck_r) // RQ3
      else $error("baud generator not restarted");
   a_sync_low_off: assert property (!ctrl_r.fs_en |-> !frame_sync_pin_o) // RQ4
      else $error("frame sync active while disabled");
   a_frame_restart: assert property ($rose(ctrl_r.fs_en) |-> bit_cnt_r == '1) // RQ5
      else $error("frame counter not restarted");
   a_tx_at_frame: assert property ($rose(tx_act_r) |-> $past(frame_start)) // RQ8
      else $error("transmit enabled off a frame edge");
   a_rx_at_frame: assert property ($rose(rx_act_r) |-> $past(frame_start)) // RQ8
      else $error("receive enabled off a frame edge");
   a_tx_req_act: assert property (tx_req_o |-> $past(tx_act_r)) // RQ9
      else $error("transmit request while inactive");
   a_tx_has_data: assert property ($rose(tx_busy) |-> $past(tbuf_valid) && $past(tx_act_nxt)) // RQ10
      else $error("shift started without data");
   a_rx_capture: assert property (rx_cnt_r != '0 |-> rx_act_r) // RQ11
      else $error("capture while receive inactive");
   a_rx_req_act: assert property (rx_req_o |-> $past(rx_act_r) && $past(rx_fifo_level_i) != '0) // RQ12
      else $error("receive request without data");
   a_tx_rst_clr: assert property (ctrl_r.tx_rst |-> !ctrl_r.tx_en && !tx_act_r && !tx_busy) // RQ13
      else $error("transmit reset left path active");
   a_rx_rst_clr: assert property (ctrl_r.rx_rst |-> !ctrl_r.rx_en && !rx_act_r) // RQ14
      else $error("receive reset left path active");
   a_stop_clear: assert property (module_stop_i |=>
      !ctrl_r.sck_en && !ctrl_r.fs_en && !ctrl_r.tx_en && !ctrl_r.rx_en) // RQ15
      else $error("module stop left enables set");
   a_rsvd_zero: assert property (wb_ack_o && $past(hit_ctrl) |->
      wb_dat_o[13:10] == 4'h0 && wb_dat_o[7:2] == 6'h00) // RQ16
      else $error("reserved bits read non-zero");
   a_txd_idle: assert property (!tx_busy && !ctrl_r.tx_rst |->
      transmit_data_pin_o && transmit_data_pin_oe_o == !$past(cfg_r.hiz)) // RQ17
      else $error("idle transmit pin wrong");
   a_transmit_path_reset_pin: assert property (ctrl_r.tx_rst |-> transmit_data_pin_o && transmit_data_pin_oe_o) // RQ18
      else $error("transmit reset pin not high");

   c_tx_word: cover property (tx_load ##[1:600] !tx_busy);
   c_rx_word: cover property (rx_word_r && rbuf_ready);
   c_rx_ovr: cover property (rx_word_r && !rbuf_ready);
   c_frame: cover property (frame_start && ctrl_r.tx_en && ctrl_r.rx_en);
endmodule : sap_port_ctrl

//--- verif/sap_codec_model.sv
`timescale 1ns/1ps
// Far-side codec: one word a frame on receive data, captures transmit data
module sap_codec_model (
   // Clock
   input wire logic clk_i,
   // Wire levels of the serial pins
   input wire logic sck_i,
   input wire logic sync_i,
   input wire logic txd_i,
   output logic rxd_o,
   // Word to send, word captured
   input wire logic [15:0] word_i,
   output logic [15:0] cap_o,
   output logic done_o
);
   logic sck_r = 1'h0;
   logic sync_r = 1'h0;
   logic [4:0] cnt_r = 5'h10;
   logic [15:0] shf_r = 16'h0000;

   // Known pin level before the first frame
   initial begin
      rxd_o = 1'h0;
      cap_o = 16'h0000;
      done_o = 1'h0;
   end

   // Edges found against last sample; data moves on falling, taken on rising
   always @(posedge clk_i) begin
      sck_r <= sck_i;
      sync_r <= sync_i;
      done_o <= 1'h0;
      if (sync_i && !sync_r) begin
         cnt_r <= 5'h00;
         rxd_o <= word_i[15];
      end else if (sck_i && !sck_r && cnt_r < 5'h10) begin
         shf_r <= {shf_r[14:0], txd_i};
         cnt_r <= cnt_r + 5'h01;
         cap_o <= {shf_r[14:0], txd_i};
         done_o <= (cnt_r == 5'h0F);
      end else if (!sck_i && sck_r && cnt_r != 5'h00) begin
         // Outside the word the line keeps changing, never resting on old data
         rxd_o <= (cnt_r < 5'h10) ? word_i[4'hF - cnt_r[3:0]] : ~rxd_o;
      end
   end
endmodule : sap_codec_model

//--- verif/tb_top.sv
`timescale 1ns/1ps
// Bench for the port operating control block
module tb_top;
   import sap_pkg::*;
   logic clk_i = 1'h0, rst_i = 1'h1;
   logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h3;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rdat;
   logic module_stop_i = 1'h0, tx_valid_i = 1'h0, rx_ready_i = 1'h0;
   logic tx_ready_o, rx_valid_o, tx_req_o, rx_req_o, done;
   logic [15:0] tx_data_i = 16'h0000, rx_data_o, cw = 16'h0000, cap, t;
   logic [4:0] tx_fifo_level_i = 5'h00, transmit_fifo_watermark_i = 5'h00;
   logic [4:0] rx_fifo_level_i = 5'h00, receive_fifo_watermark_i = 5'h00;
   logic [4:0] a, b, e, f;
   logic serial_clock_pin_i, serial_clock_pin_o, serial_clock_pin_oe_o;
   logic frame_sync_pin_i, frame_sync_pin_o, frame_sync_pin_oe_o;
   logic transmit_data_pin_o, transmit_data_pin_oe_o, receive_data_pin_i, txd_w;
   logic [31:0] v;
   logic [15:0] tq[$], cq[$];
   int miscompares = 0, comparisons = 0, seed = 89, i, j, k, n;

   // Clock
   always #5 clk_i = ~clk_i;

   // Wire levels; a released transmit line shows the inverse of its last level
   assign serial_clock_pin_i = serial_clock_pin_oe_o ? serial_clock_pin_o : 1'h0;
   assign frame_sync_pin_i = frame_sync_pin_oe_o ? frame_sync_pin_o : 1'h0;
   assign txd_w = transmit_data_pin_oe_o ? transmit_data_pin_o : ~transmit_data_pin_o;

   sap_port_ctrl u_sap_port_ctrl (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .module_stop_i, .tx_data_i, .tx_valid_i,
      .tx_ready_o, .rx_data_o, .rx_valid_o, .rx_ready_i, .tx_fifo_level_i,
      .transmit_fifo_watermark_i, .rx_fifo_level_i, .receive_fifo_watermark_i,
      .tx_req_o, .rx_req_o, .serial_clock_pin_i, .serial_clock_pin_o,
      .serial_clock_pin_oe_o, .frame_sync_pin_i, .frame_sync_pin_o,
      .frame_sync_pin_oe_o, .transmit_data_pin_o, .transmit_data_pin_oe_o,
      .receive_data_pin_i
   );

   sap_codec_model u_sap_codec_model (
      .clk_i(clk_i), .sck_i(serial_clock_pin_i), .sync_i(frame_sync_pin_i),
      .txd_i(txd_w), .rxd_o(receive_data_pin_i), .word_i(cw), .cap_o(cap),
      .done_o(done)
   );

   task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
      comparisons++;
      if (got !== ex) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask : check

   task automatic tick(input int c);
      repeat (c) @(posedge clk_i);
   endtask : tick

   // Classic single Wishbone cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int c;
      c = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= ad;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         c++;
      end while (wb_ack_o !== 1'h1 && c < 20);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_we_i <= 1'h0;
      @(posedge clk_i);
      if (c >= 20) check("bus ack", 1, 0);
   endtask : bus

   task automatic rd(input logic [7:0] ad, input logic [31:0] ex, input string nm);
      bus(1'h0, ad, 32'h0000_0000);
      check(nm, ex, rdat);
   endtask : rd

   // One word into the transmit buffer
   task automatic push(input logic [15:0] w);
      int c;
      c = 0;
      @(posedge clk_i);
      tx_valid_i <= 1'h1;
      tx_data_i <= w;
      do begin
         @(posedge clk_i);
         c++;
      end while (tx_ready_o !== 1'h1 && c < 20);
      tx_valid_i <= 1'h0;
      if (c >= 20) check("push ready", 1, 0);
   endtask : push

   // Expected values
   function automatic logic [31:0] exp_ctrl(input logic [31:0] r);
      logic [15:0] m;
      m = r[15:0] & CTRL_WMASK;
      if (m[1]) m[9] = 1'h0;
      if (m[0]) m[8] = 1'h0;
      return {16'h0000, m};
   endfunction : exp_ctrl

   function automatic logic exp_rreq(input logic [4:0] l, input logic [4:0] w);
      return (l != 5'h00) && (l >= w);
   endfunction : exp_rreq

   task automatic stop_test;
      $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   // Watchdog
   initial begin
      #200000;
      miscompares++;
      $display("[FAIL] watchdog expected finish seen hang");
      stop_test();
   end

   // Main sequence
   initial begin
      tick(12);
      rst_i <= 1'h0;
      rd(CTRL_OFS, {16'h0000, CTRL_RST}, "ctrl reset");
      rd(CFG_OFS, {16'h0000, CFG_RST}, "cfg reset");
      rd(8'h0C, 32'h0000_0000, "unmapped");
      check("sck off", 0, serial_clock_pin_o);
      check("sync off", 0, frame_sync_pin_o);
      check("sck oe", 1, serial_clock_pin_oe_o);
      check("sync oe", 1, frame_sync_pin_oe_o);
      check("txd oe reset", 1, transmit_data_pin_oe_o);
      for (i = 0; i < 8; i++) begin
         v = $random(seed);
         bus(1'h1, CTRL_OFS, v & {16'h0000, CTRL_WMASK});
         rd(CTRL_OFS, exp_ctrl(v), "ctrl rw");
      end
      bus(1'h1, CTRL_OFS, 32'h0000_0303);
      rd(CTRL_OFS, 32'h0000_0003, "path reset");
      check("txd reset", 1, transmit_data_pin_o);
      bus(1'h1, CTRL_OFS, 32'h0000_0000);
      bus(1'h1, CFG_OFS, 32'h0000_0703);
      tick(2);
      check("txd float", 0, transmit_data_pin_oe_o);
      bus(1'h1, CFG_OFS, 32'h0000_0701);
      tick(2);
      check("txd drive", 1, transmit_data_pin_oe_o);
      check("txd idle", 1, transmit_data_pin_o);
      $display("test registers done");
      // Fill transmit buffer with two words, check it refuses more, receiver stalls throughout
      for (i = 0; i < 2; i++) begin
         t = $random(seed);
         tq.push_back(t);
         push(t);
      end
      tick(2);
      check("tx full", 0, tx_ready_o);
      t = $random(seed);
      cq.push_back(t);
      cw <= t;
      bus(1'h1, CTRL_OFS, 32'h0000_C300);
      check("sck start", 0, serial_clock_pin_o);
      n = 0;
      while (serial_clock_pin_o !== 1'h1 && n < 30) begin
         tick(1);
         n++;
      end
      check("sck half", 1, n >= 4 && n <= 10);
      for (k = 0; k < 3; k++) begin
         n = 0;
         do begin
            @(posedge clk_i);
            n++;
         end while (done !== 1'h1 && n < 2000);
         check("frame end", 1, done);
         check("tx word", k < 2 ? tq[k] : 16'hFFFF, cap);
         t = $random(seed);
         cq.push_back(t);
         cw <= t;
         for (j = 0; k == 0 && j < 6; j++) begin
            v = $random(seed);
            a = v[4:0];
            e = (j == 1) ? 5'h00 : v[14:10];
            b = (j == 0) ? a : v[9:5];
            f = (j == 0) ? e : v[19:15];
            @(posedge clk_i);
            tx_fifo_level_i <= a;
            transmit_fifo_watermark_i <= b;
            rx_fifo_level_i <= e;
            receive_fifo_watermark_i <= f;
            tick(3);
            check("tx req", a <= b, tx_req_o);
            check("rx req", exp_rreq(e, f), rx_req_o);
         end
      end
      tick(8);
      bus(1'h0, STAT_OFS, 32'h0000_0000);
      check("overrun", 1, rdat[STAT_OVR_BIT]);
      bus(1'h1, STAT_OFS, 32'h0000_0008);
      bus(1'h0, STAT_OFS, 32'h0000_0000);
      check("overrun clr", 0, rdat[STAT_OVR_BIT]);
      // Drain the receive buffer until empty
      rx_ready_i <= 1'h1;
      k = 0;
      n = 0;
      while (k < 2 && n < 50) begin
         @(posedge clk_i);
         n++;
         if (rx_valid_o === 1'h1) begin
            check("rx word", cq[k], rx_data_o);
            k++;
         end
      end
      check("rx count", 2, k);
      $display("test frames done");
      @(posedge clk_i);
      module_stop_i <= 1'h1;
      @(posedge clk_i);
      module_stop_i <= 1'h0;
      rd(CTRL_OFS, 32'h0000_0000, "stop ctrl");
      tick(3);
      check("stop sck", 0, serial_clock_pin_o);
      check("stop sync", 0, frame_sync_pin_o);
      $display("test stop done");
      stop_test();
   end
endmodule : tb_top
